// ---- st_line_peer.sv ----
// line peer model sending downstream multiframes
`timescale 1ns/1ps
module st_line_peer
(
	input wire clk_in,
	input wire rst_in,
	input wire run_in,
	input wire err_in,
	output reg strobe_out,
	output reg fa_out,
	output reg m_out,
	output reg s_out,
	output reg [4:0] frame_out
);
// ------------------------------
// frame timing, eight cycles a frame
// ------------------------------
reg [2:0] phase; // position inside the frame
wire [4:0] next_frame = (frame_out == 5'h14) ? 5'h1 : frame_out + 5'h1;
wire fa_slot = (next_frame % 5'h5) == 5'h1; // frames 1,6,11,16
always @(posedge clk_in or posedge rst_in)
begin
	if (rst_in)
	begin
		phase <= 3'h0;
		strobe_out <= 1'b0;
		{fa_out, m_out, s_out} <= 3'h0;
		frame_out <= 5'h0;
	end
	else
	begin
		phase <= phase + 3'h1;
		strobe_out <= (phase == 3'h7) && run_in;
		if (!run_in)
			frame_out <= 5'h0; // restart at frame 1
		if (phase == 3'h7 && run_in)
		begin
			frame_out <= next_frame;
			fa_out <= fa_slot | (err_in && next_frame == 5'h2); // fault only on command
			m_out <= next_frame == 5'h1;
			s_out <= next_frame[0];
		end
		else
			{fa_out, m_out, s_out} <= ~{fa_out, m_out, s_out}; // no valid bit here
	end
end
endmodule // st_line_peer

// ---- st_mf_checker.sv ----
// assertion checker for the multiframe block ports
`timescale 1ns/1ps
module st_mf_checker
(
	input wire clk_in,
	input wire rst_in,
	input wire [3:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_readdata_out,
	input wire avs_waitrequest_out,
	input wire frame_strobe_in,
	input wire rx_m_in,
	input wire tx_fa_out,
	input wire tx_m_out,
	input wire tx_s_out,
	input wire shared_aux_pin_out,
	input wire line_valid_in,
	input wire [7:0] sys_b1_out,
	input wire sys_valid_in,
	input wire [7:0] tx_b1_out,
	input wire multiframe_tick_irq_out,
	input wire sq_change_irq_out
);
// ------------------------------
// bus and frame relations
// ------------------------------
default clocking cb @(posedge clk_in); endclocking
default disable iff (rst_in);
wire req = avs_read_in | avs_write_in; // any pending access
wait_answer_a: assert property ($rose(req) |=> !avs_waitrequest_out)
	else $error("no answer one cycle after request");
wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
	else $error("waitrequest low longer than one cycle");
wait_cause_a: assert property (!avs_waitrequest_out |-> req)
	else $error("answer without request");
unmapped_zero_a: assert property (avs_read_in && avs_address_in[1:0] != 2'h0
	&& !avs_waitrequest_out |-> avs_readdata_out == 32'h0)
	else $error("unmapped read not zero");
idle_data_a: assert property (!req |=> $stable(avs_readdata_out))
	else $error("read data moved while idle");
frame_hold_a: assert property (!frame_strobe_in |=> $stable({tx_fa_out, tx_m_out, tx_s_out}))
	else $error("frame bits moved between strobes");
pin_mirror_a: assert property (frame_strobe_in |=> shared_aux_pin_out == $past(rx_m_in))
	else $error("pin does not follow received m bit");
tick_source_a: assert property (multiframe_tick_irq_out |-> $past(frame_strobe_in)
	##1 !multiframe_tick_irq_out)
	else $error("tick not a pulse after a strobe");
change_source_a: assert property (sq_change_irq_out |-> $past(frame_strobe_in))
	else $error("change pulse without strobe");
data_hold_a: assert property (!line_valid_in |=> $stable(sys_b1_out))
	else $error("system data moved without valid");
tx_hold_a: assert property (!sys_valid_in |=> $stable(tx_b1_out))
	else $error("line data moved without valid");
cover property (multiframe_tick_irq_out);
cover property (sq_change_irq_out);
cover property (avs_read_in && !avs_waitrequest_out);
endmodule // st_mf_checker
bind st_multiframe_and_pin_a_sync st_mf_checker u_chk
(
	.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.frame_strobe_in(frame_strobe_in), .rx_m_in(rx_m_in), .tx_fa_out(tx_fa_out),
	.tx_m_out(tx_m_out), .tx_s_out(tx_s_out), .shared_aux_pin_out(shared_aux_pin_out),
	.line_valid_in(line_valid_in), .sys_b1_out(sys_b1_out), .sys_valid_in(sys_valid_in),
	.tx_b1_out(tx_b1_out), .multiframe_tick_irq_out(multiframe_tick_irq_out),
	.sq_change_irq_out(sq_change_irq_out)
);

// ---- st_multiframe_and_pin_a_sync.v ----
// multiframe framer, m-bit sync pin and data gating for an s/t transceiver
`timescale 1ns/1ps
`include "st_multiframe_regs.vh"

module st_multiframe_and_pin_a_sync
(
	input wire clk_in,
	input wire rst_in,
	input wire [3:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	output reg [31:0] avs_readdata_out,
	output reg avs_waitrequest_out,
	input wire frame_strobe_in,
	input wire rx_fa_in,
	input wire rx_m_in,
	input wire rx_s_in,
	output reg tx_fa_out,
	output reg tx_m_out,
	output reg tx_s_out,
	input wire shared_aux_pin_in,
	output reg shared_aux_pin_out,
	output reg shared_aux_pin_oe_out,
	input wire activated_state_in,
	input wire activate_req_in,
	input wire line_valid_in,
	input wire [7:0] line_b1_in,
	input wire [7:0] line_b2_in,
	input wire [1:0] line_d_in,
	input wire [1:0] line_e_in,
	output reg [7:0] sys_b1_out,
	output reg [7:0] sys_b2_out,
	output reg [1:0] sys_d_out,
	output reg [1:0] sys_e_out,
	input wire sys_valid_in,
	input wire [7:0] sys_b1_in,
	input wire [7:0] sys_b2_in,
	input wire [1:0] sys_d_in,
	output reg [7:0] tx_b1_out,
	output reg [7:0] tx_b2_out,
	output reg [1:0] tx_d_out,
	output reg multiframe_tick_irq_out,
	output reg sq_change_irq_out
);

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// next frame number, 1..20 with wrap
	function [4:0] f_wrap;
		input [4:0] c;
		begin
			f_wrap = (c == `MF_FRAMES) ? 5'h01 : c + 5'h01;
		end
	endfunction

	// fa pattern: one in frames 1, 6, 11, 16
	function f_fa;
		input [4:0] c;
		begin
			f_fa = (c == 5'h01) | (c == 5'h06) | (c == 5'h0B) | (c == 5'h10);
		end
	endfunction

	// which of the four q / s1 slots a frame belongs to
	function [1:0] f_slot;
		input [4:0] c;
		begin
			f_slot = (c < 5'h06) ? 2'h0 : (c < 5'h0B) ? 2'h1 : (c < 5'h10) ? 2'h2 : 2'h3;
		end
	endfunction

	// sync states, one-hot
	localparam [2:0] ST_HUNT = 3'h1;
	localparam [2:0] ST_ACQ = 3'h2;
	localparam [2:0] ST_SYNC = 3'h4;

	// -----------------------------------------------------------------
	// registers and state
	// -----------------------------------------------------------------
	reg [11:0] ctrl; // mode, pin select, l1 control, priority
	reg [4:0] sq_tx; // q or s1 bits plus enable
	reg [3:0] sq_rx; // last complete received s1 or q bits
	reg [3:0] shadow; // bits collected in the running multiframe
	reg [4:0] cnt; // multiframe frame number
	reg [2:0] state; // te sync state
	reg good; // one clean multiframe already seen
	reg bad; // one faulty multiframe already seen
	reg mf_err; // error inside the running multiframe
	reg aux_meta; // pin synchroniser, first stage
	reg aux_sync; // pin synchroniser, second stage
	reg [3:0] echo_ones; // consecutive echo ones
	reg bus_busy; // access taken, answer pending

	// -----------------------------------------------------------------
	// decoded control
	// -----------------------------------------------------------------
	wire [1:0] mode = ctrl[`CTRL_MODE_LO+1:`CTRL_MODE_LO];
	wire nt_like = (mode == `MODE_NT) | (mode == `MODE_LTS);
	wire te_mode = (mode == `MODE_TE);
	wire aux_sel = ctrl[`CTRL_AUX_SEL];
	wire l1_dis = ctrl[`CTRL_L1_DIS];
	wire [2:0] transmit_info_field = ctrl[`CTRL_TRANSMIT_INFO_FIELD_LO+2:`CTRL_TRANSMIT_INFO_FIELD_LO];
	wire [2:0] prio = ctrl[`CTRL_PRIO_LO+2:`CTRL_PRIO_LO];
	wire mf_en = sq_tx[`SQTX_MULTIFRAME_ENABLE];
	wire in_sync = (state == ST_SYNC);
	// a stuck-high m-bit input holds the count only when the pin is ours
	wire pin_a_hold = aux_sel & aux_sync;
	// frame number for the frame now being handled
	reg [4:0] n;
	// bit errors against the expected pattern
	wire pos_err = (rx_fa_in != f_fa(n)) | (rx_m_in != (n == 5'h01));
	wire mf_end = (n == `MF_FRAMES) & (nt_like ? (mf_en & ~pin_a_hold) : ~state[0]);
	reg [3:0] next_shadow;

	// frame number for this strobe, per mode
	always @*
	begin
		n = cnt;
		next_shadow = shadow;
		if (nt_like)
		begin
			// disabled or held: park at frame 20 so all bits go out zero
			if (~mf_en | pin_a_hold)
				n = `MF_FRAMES;
			else
				n = f_wrap(cnt);
			if (f_fa(n))
				next_shadow[f_slot(n)] = rx_fa_in;
		end
		else
		begin
			// while hunting, a received m marks frame 1
			if (state == ST_HUNT)
				n = rx_m_in ? 5'h01 : `MF_FRAMES;
			else
				n = f_wrap(cnt);
			if (f_fa(n))
				next_shadow[f_slot(n)] = rx_s_in;
		end
	end

	// -----------------------------------------------------------------
	// pin synchroniser
	// -----------------------------------------------------------------
	// two stages, the first feeds only the second
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			aux_meta <= 1'b0;
			aux_sync <= 1'b0;
		end
		else
		begin
			aux_meta <= shared_aux_pin_in;
			aux_sync <= aux_meta;
		end
	end

	// -----------------------------------------------------------------
	// multiframe counter, sync machine and frame bits
	// -----------------------------------------------------------------
	// everything advances once per frame, at the f bit strobe
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt <= `MF_FRAMES;
			state <= ST_HUNT;
			good <= 1'b0;
			bad <= 1'b0;
			mf_err <= 1'b0;
			shadow <= 4'h0;
			sq_rx <= 4'h0;
			tx_fa_out <= 1'b0;
			tx_m_out <= 1'b0;
			tx_s_out <= 1'b0;
			shared_aux_pin_out <= 1'b0;
			multiframe_tick_irq_out <= 1'b0;
			sq_change_irq_out <= 1'b0;
		end
		else
		begin
			// interrupts are single-cycle pulses
			multiframe_tick_irq_out <= 1'b0;
			sq_change_irq_out <= 1'b0;
			if (frame_strobe_in)
			begin
				cnt <= n;
				shadow <= next_shadow;
				// te side puts the received m on the pin each frame
				shared_aux_pin_out <= rx_m_in;
				if (nt_like)
				begin
					// downstream fa, m and s1 from the frame number
					tx_fa_out <= f_fa(n);
					tx_m_out <= (n == 5'h01);
					tx_s_out <= f_fa(n) & sq_tx[f_slot(n)];
					state <= ST_HUNT;
				end
				else
				begin
					tx_m_out <= 1'b0;
					tx_s_out <= 1'b0;
					// q only once locked, else echo the received fa
					if (in_sync)
						tx_fa_out <= f_fa(n) & sq_tx[f_slot(n)];
					else
						tx_fa_out <= rx_fa_in;
					if (~mf_en)
						state <= ST_HUNT;
					else
					begin
						case (state)
							ST_HUNT:
							begin
								// first m seen: start counting
								good <= 1'b0;
								bad <= 1'b0;
								mf_err <= 1'b0;
								if (rx_m_in)
									state <= ST_ACQ;
							end
							ST_ACQ:
							begin
								if (pos_err)
									state <= ST_HUNT;
								else if (n == `MF_FRAMES)
								begin
									good <= 1'b1;
									if (good)
										state <= ST_SYNC;
								end
							end
							ST_SYNC:
							begin
								if (n == `MF_FRAMES)
								begin
									mf_err <= 1'b0;
									// one good multiframe forgives one bad one
									if (mf_err | pos_err)
									begin
										bad <= 1'b1;
										if (bad)
											state <= ST_HUNT;
									end
									else
										bad <= 1'b0;
								end
								else if (pos_err)
									mf_err <= 1'b1;
							end
							default:
								state <= ST_HUNT;
						endcase
					end
				end
				// end of a multiframe: tick, and report changed data
				if (mf_end)
				begin
					multiframe_tick_irq_out <= 1'b1;
					sq_rx <= next_shadow;
					if (next_shadow != sq_rx)
						sq_change_irq_out <= 1'b1;
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// data path gating between line and system bus
	// -----------------------------------------------------------------
	wire rx_open = activated_state_in | (l1_dis & (transmit_info_field == `TRANSMIT_INFO_FIELD_OPEN));
	wire tx_open = (activated_state_in & activate_req_in) | (l1_dis & ~ctrl[`CTRL_TDD]);
	// echo evaluation applies to te only; bit 0 of the field turns it on
	wire eval_on = te_mode & prio[0];
	wire [3:0] prio_need = ctrl[`CTRL_PRIO_CLASS] ? `PRIO_HIGH_ONES : `PRIO_LOW_ONES;
	wire d_access = ~eval_on | (echo_ones >= prio_need);
	reg [3:0] next_echo;
	integer i;

	// count echo ones, any zero restarts the wait
	always @*
	begin
		next_echo = echo_ones;
		for (i = 1; i >= 0; i = i - 1)
		begin
			if (~line_e_in[i])
				next_echo = 4'h0;
			else if (next_echo != 4'hF)
				next_echo = next_echo + 4'h1;
		end
	end

	// echo counter and both data directions
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			echo_ones <= 4'h0;
			sys_b1_out <= 8'hFF;
			sys_b2_out <= 8'hFF;
			sys_d_out <= 2'h3;
			sys_e_out <= 2'h3;
			tx_b1_out <= 8'hFF;
			tx_b2_out <= 8'hFF;
			tx_d_out <= 2'h3;
			shared_aux_pin_oe_out <= 1'b0;
		end
		else
		begin
			// pin drives only as m-bit output in te and lt-t
			shared_aux_pin_oe_out <= aux_sel & ~nt_like;
			if (line_valid_in)
			begin
				echo_ones <= next_echo;
				// closed path sends all ones
				sys_b1_out <= rx_open ? line_b1_in : 8'hFF;
				sys_b2_out <= rx_open ? line_b2_in : 8'hFF;
				sys_d_out <= rx_open ? line_d_in : 2'h3;
				// echo passes in te only
				sys_e_out <= (rx_open & te_mode) ? line_e_in : 2'h3;
			end
			if (sys_valid_in)
			begin
				tx_b1_out <= tx_open ? sys_b1_in : 8'hFF;
				tx_b2_out <= tx_open ? sys_b2_in : 8'hFF;
				// d waits for enough echo ones under priority
				tx_d_out <= (tx_open & d_access) ? sys_d_in : 2'h3;
			end
		end
	end

	// -----------------------------------------------------------------
	// avalon-mm slave
	// -----------------------------------------------------------------
	wire bus_req = avs_read_in | avs_write_in;
	wire [1:0] word = avs_address_in[3:2];
	wire mapped = (avs_address_in[1:0] == 2'h0);

	// first edge latches read data, second edge commits and releases
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ctrl <= `CTRL_RESET;
			sq_tx <= `SQTX_RESET;
			bus_busy <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h0;
		end
		else if (bus_req & ~bus_busy)
		begin
			bus_busy <= 1'b1;
			avs_waitrequest_out <= 1'b0;
			avs_readdata_out <= 32'h0;
			if (mapped & avs_read_in)
			begin
				case (word)
					`OFS_CTRL: avs_readdata_out <= {20'h0, ctrl};
					`OFS_SQ_TX: avs_readdata_out <= {27'h0, sq_tx};
					`OFS_SQ_RX: avs_readdata_out <= {27'h0, in_sync, sq_rx};
					`OFS_STATUS: avs_readdata_out <= {24'h0, cnt, state};
					default: avs_readdata_out <= 32'h0;
				endcase
			end
		end
		else if (bus_busy)
		begin
			// unmapped writes and status writes are dropped
			bus_busy <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			if (avs_write_in & mapped)
			begin
				if (word == `OFS_CTRL)
				begin
					if (avs_byteenable_in[0])
						ctrl[7:0] <= avs_writedata_in[7:0];
					if (avs_byteenable_in[1])
						ctrl[11:8] <= avs_writedata_in[11:8];
				end
				if ((word == `OFS_SQ_TX) & avs_byteenable_in[0])
					sq_tx <= avs_writedata_in[4:0];
			end
		end
	end

endmodule // st_multiframe_and_pin_a_sync

// ---- st_multiframe_regs.vh ----
// register offsets, field positions, reset values and counts of the multiframe block
`ifndef ST_MULTIFRAME_REGS_VH
`define ST_MULTIFRAME_REGS_VH
// word indices on the register bus, taken from address bits 3:2
`define OFS_CTRL 2'h0
`define OFS_SQ_TX 2'h1
`define OFS_SQ_RX 2'h2
`define OFS_STATUS 2'h3
// control register fields
`define CTRL_MODE_LO 0
`define CTRL_AUX_SEL 2
`define CTRL_L1_DIS 3
`define CTRL_TDD 4
`define CTRL_TRANSMIT_INFO_FIELD_LO 5
`define CTRL_PRIO_LO 8
`define CTRL_PRIO_CLASS 11
`define CTRL_RESET 12'h010
// s/q transmit register fields
`define SQTX_MULTIFRAME_ENABLE 4
`define SQTX_RESET 5'h00
// s/q receive register fields
`define SQRX_SYNC 4
// operating modes
`define MODE_TE 2'h0
`define MODE_NT 2'h1
`define MODE_LTS 2'h2
`define MODE_LTT 2'h3
// transmit info code that opens the receive data path
`define TRANSMIT_INFO_FIELD_OPEN 3'h3
// multiframe length and priority echo counts
`define MF_FRAMES 5'h14
`define PRIO_LOW_ONES 4'h8
`define PRIO_HIGH_ONES 4'hA
`endif

// ---- tb.sv ----
// self-checking bench for the multiframe block
`timescale 1ns/1ps
module tb;
reg clk_in = 1'b0, rst_in = 1'b1, rd = 1'b0, wr = 1'b0, pin = 1'b0, act = 1'b0, areq = 1'b0;
reg lv = 1'b0, sv = 1'b0, run = 1'b0, err = 1'b0, cfa, cm;
reg [1:0] ev = 2'h2; // echo bits sent with each line unit
reg [3:0] adr = 4'h0;
reg [31:0] wd = 32'h0, rdat;
reg [7:0] lb1 = 8'h0, lb2 = 8'h0, sb1 = 8'h0, sb2 = 8'h0;
reg [1:0] ld = 2'h0, le = 2'h0, sd = 2'h0;
reg [4:0] cf;
wire [31:0] rdata;
wire waitreq, stb, rfa, rm, rs, tfa, tm, ts, po, poe, tick, chg;
wire [4:0] pfr;
wire [7:0] yb1, yb2, xb1, xb2;
wire [1:0] yd, ye, xd;
integer num_errors = 0, n_tests = 0, cyc = 0, nt = 0, nc = 0, i;
initial forever #5 clk_in = ~clk_in;
st_line_peer PEER (.clk_in(clk_in), .rst_in(rst_in), .run_in(run), .err_in(err),
	.strobe_out(stb), .fa_out(rfa), .m_out(rm), .s_out(rs), .frame_out(pfr));
st_multiframe_and_pin_a_sync DUT (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr),
	.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'h3),
	.avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .frame_strobe_in(stb),
	.rx_fa_in(rfa), .rx_m_in(rm), .rx_s_in(rs), .tx_fa_out(tfa), .tx_m_out(tm), .tx_s_out(ts),
	.shared_aux_pin_in(pin), .shared_aux_pin_out(po), .shared_aux_pin_oe_out(poe),
	.activated_state_in(act), .activate_req_in(areq), .line_valid_in(lv), .line_b1_in(lb1),
	.line_b2_in(lb2), .line_d_in(ld), .line_e_in(le), .sys_b1_out(yb1), .sys_b2_out(yb2),
	.sys_d_out(yd), .sys_e_out(ye), .sys_valid_in(sv), .sys_b1_in(sb1), .sys_b2_in(sb2),
	.sys_d_in(sd), .tx_b1_out(xb1), .tx_b2_out(xb2), .tx_d_out(xd),
	.multiframe_tick_irq_out(tick), .sq_change_irq_out(chg));
// ------------------------------
// checking and bus tasks
// ------------------------------
task results;
begin
	$display("errors %0d comparisons %0d", num_errors, n_tests);
	if (num_errors == 0 && n_tests > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
end
endtask
task chk(input [31:0] got, input [31:0] exp);
begin
	n_tests = n_tests + 1;
	if (got !== exp)
	begin
		num_errors = num_errors + 1;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
	end
end
endtask
// request held until waitrequest is seen low
task bus(input w, input [3:0] a, input [31:0] d);
begin
	@(posedge clk_in);
	adr <= a;
	wd <= d;
	rd <= !w;
	wr <= w;
	@(posedge clk_in);
	while (waitreq !== 1'b0)
		@(posedge clk_in);
	rdat = rdata;
	rd <= 1'b0;
	wr <= 1'b0;
end
endtask
// next frame strobe, received bits kept
task step(input integer n);
begin
	repeat (n)
	begin
		@(posedge clk_in);
		while (stb !== 1'b1)
			@(posedge clk_in);
		cfa = rfa;
		cm = rm;
		cf = pfr;
		#1;
	end
end
endtask
// one data unit both ways; expected passed or all ones, d only with access
task xfer(input ro, input to, input te, input dk);
begin
	@(posedge clk_in);
	{lb1, lb2, ld, le, lv} <= {8'h5A, 8'hC3, 2'h1, ev, 1'b1};
	{sb1, sb2, sd, sv} <= {8'h96, 8'h3C, 2'h2, 1'b1};
	@(posedge clk_in);
	{lv, sv} <= 2'h0;
	@(posedge clk_in);
	#1;
	chk({yb1, yb2, yd}, ro ? 18'h16B0D : 18'h3FFFF);
	chk(ye, (ro && te) ? ev : 2'h3);
	chk({xb1, xb2, xd}, to ? {16'h963C, dk ? 2'h2 : 2'h3} : 18'h3FFFF);
end
endtask
function [2:0] eb(input [4:0] f, input [3:0] q); // expected {fa, m, s}
	eb = {f % 5'h5 == 5'h1, f == 5'h1, (f % 5'h5 == 5'h1) & q[(f - 5'h1) / 5'h5]};
endfunction
// timeout and interrupt counting
always @(posedge clk_in)
begin
	cyc = cyc + 1;
	if (tick === 1'b1)
		nt = nt + 1;
	if (chg === 1'b1)
		nc = nc + 1;
	if (cyc == 5000)
	begin
		num_errors = num_errors + 1;
		results;
	end
end
// ------------------------------
// main sequence
// ------------------------------
initial
begin
	repeat (4) @(posedge clk_in);
	rst_in <= 1'b0;
	bus(0, 4'h0, 0);
	chk(rdat, 32'h010);
	bus(0, 4'h4, 0);
	chk(rdat, 32'h0);
	bus(0, 4'hC, 0);
	chk(rdat, 32'hA1);
	bus(1, 4'h8, 32'h1F);
	bus(0, 4'h8, 0);
	chk(rdat, 32'h0);
	bus(0, 4'h1, 0);
	chk(rdat, 32'h0);
	run <= 1'b1;
	bus(1, 4'h0, 32'h015);
	for (i = 0; i < 3; i = i + 1)
	begin
		step(1);
		chk({tfa, tm, ts}, 0);
	end
	chk(poe, 0);
	bus(1, 4'h4, 32'h1A);
	nt = 0;
	for (i = 1; i < 22; i = i + 1)
	begin
		step(1);
		chk({tfa, tm, ts}, eb(i % 20, 4'hA));
	end
	chk(nt, 1);
	@(posedge clk_in);
	pin <= 1'b1;
	bus(1, 4'h4, 32'h1B);
	nt = 0;
	for (i = 0; i < 3; i = i + 1)
	begin
		step(1);
		chk({tfa, tm, ts}, 0);
	end
	chk(nt, 0);
	bus(0, 4'hC, 0);
	chk(rdat[7:3], 5'h14);
	@(posedge clk_in);
	pin <= 1'b0;
	step(1);
	chk({tfa, tm, ts}, 3'h7);
	@(posedge clk_in);
	rst_in <= 1'b1;
	run <= 1'b0;
	repeat (2) @(posedge clk_in);
	rst_in <= 1'b0;
	bus(1, 4'h0, 32'h014);
	bus(1, 4'h4, 32'h15);
	run <= 1'b1;
	for (i = 0; i < 20; i = i + 1)
	begin
		step(1);
		chk(tfa, cfa);
		chk(po, cm);
	end
	chk(poe, 1);
	bus(0, 4'h8, 0);
	chk(rdat[4], 0);
	step(20);
	bus(0, 4'h8, 0);
	chk(rdat[4:0], 5'h15);
	for (i = 0; i < 20; i = i + 1)
	begin
		step(1);
		chk(tfa, eb(cf, 4'h5) & 3'h1);
	end
	chk(nc != 0, 1);
	@(posedge clk_in);
	err <= 1'b1;
	step(20);
	bus(0, 4'h8, 0);
	chk(rdat[4], 1);
	step(20);
	bus(0, 4'h8, 0);
	chk(rdat[4], 0);
	@(posedge clk_in);
	err <= 1'b0;
	xfer(0, 0, 1, 1);
	@(posedge clk_in);
	act <= 1'b1;
	xfer(1, 0, 1, 1);
	@(posedge clk_in);
	areq <= 1'b1;
	xfer(1, 1, 1, 1);
	@(posedge clk_in);
	{act, areq} <= 2'h0;
	bus(1, 4'h0, 32'h068);
	xfer(1, 1, 1, 1);
	bus(1, 4'h0, 32'h078);
	xfer(1, 0, 1, 1);
	bus(1, 4'h0, 32'h069);
	xfer(1, 1, 0, 1);
	bus(1, 4'h0, 32'h011);
	xfer(0, 0, 0, 1);
	// evaluation on, class eight: d waits for eight echo ones in a row
	bus(1, 4'h0, 32'h168);
	ev = 2'h3;
	for (i = 0; i < 5; i = i + 1)
		xfer(1, 1, 1, i == 4);
	results;
end
endmodule // tb
